/* File: common/lane_status_regs.vh */
// Register map, field positions, reset values and sizes for the lane status block
`ifndef LANE_STATUS_REGS_VH
`define LANE_STATUS_REGS_VH

// ===========================================
// Sizes
`define LS_ADDR_W 12
`define LS_DATA_W 8
`define LS_LANES 8
`define LS_LINKS 2
`define LS_ALL_LANES 16
`define LS_CNT_W 8

// ===========================================
// Register offsets
`define LS_OFF_LINK_PAGE 12'h300
`define LS_OFF_CNT_CLEAR 12'h301
`define LS_OFF_THRESHOLD 12'h302
`define LS_OFF_IRQ_STATUS 12'h303
`define LS_OFF_IRQ_MASK 12'h304
`define LS_OFF_KCHAR_FLAGS 12'h46F
`define LS_OFF_LOCK_FLAGS 12'h470

// ===========================================
// Fields and reset values
`define LS_PAGE_BIT 0
`define LS_CLEAR_BIT 0
`define LS_IRQ_KCHAR_BIT 0
`define LS_IRQ_LOST_BIT 1
`define LS_IRQ_GAINED_BIT 2
`define LS_IRQ_W 3
`define LS_RST_FLAGS 8'h00
`define LS_RST_THRESHOLD 8'hFF
`define LS_RST_IRQ 3'h0
`define LS_RD_ZERO 8'h00

// ===========================================
// Code group lock counts
`define LS_LOCK_COMMAS 3'h4
`define LS_RELOCK_GOOD 3'h4
`define LS_DROP_ERRORS 3'h3
`define LS_CNT_ONE 8'h01
`define LS_CNT_MAX 8'hFF
`define LS_SMALL_ONE 3'h1
`define LS_SMALL_ZERO 3'h0

`endif

/* File: hdl/lane_error_counter.v */
// Per-lane unexpected control character counter with threshold flag
`timescale 1ns/1ns
`include "lane_status_regs.vh"

module lane_error_counter (
  input wire clock,
  input wire rst,
  input wire clearCount,
  input wire charValid,
  input wire charIsControl,
  input wire controlExpected,
  input wire [7:0] errorCountThreshold,
  output reg [7:0] errorCount_reg,
  output reg badControlCharFlag_reg
);

  wire badChar;
  reg [7:0] errorCount_next;

  // A control character where data was due
  assign badChar = charValid & charIsControl & ~controlExpected;

  // Saturating count of bad characters
  always @* begin
    errorCount_next = errorCount_reg;
    if (clearCount) begin
      errorCount_next = 8'h00;
    end else if (badChar && errorCount_reg != `LS_CNT_MAX) begin
      errorCount_next = errorCount_reg + `LS_CNT_ONE;
    end
  end

  // Count and flag registers, flag low out of reset
  always @(posedge clock) begin
    if (rst) begin
      errorCount_reg <= 8'h00;
      badControlCharFlag_reg <= 1'b0;
    end else begin
      errorCount_reg <= errorCount_next;
      badControlCharFlag_reg <= (errorCount_next >= errorCountThreshold);
    end
  end

endmodule // lane_error_counter

/* File: hdl/lane_lock_fsm.v */
// Per-lane code group synchronization state machine
`timescale 1ns/1ns
`include "lane_status_regs.vh"

module lane_lock_fsm (
  input wire clock,
  input wire rst,
  input wire charValid,
  input wire charIsComma,
  input wire charCodeError,
  output wire codeGroupLock
);

  localparam HUNT = 3'b001;
  localparam LOCKED = 3'b010;
  localparam CHECK = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [2:0] tally_reg;
  reg [2:0] tally_next;

  // Lock is held in LOCKED and through the recheck window
  assign codeGroupLock = ~state_reg[0];

  // Hunt for commas, drop lock after repeated code errors
  always @* begin
    state_next = state_reg;
    tally_next = tally_reg;
    case (state_reg)
      HUNT: begin
        if (charValid) begin
          if (!charIsComma || charCodeError) begin
            tally_next = `LS_SMALL_ZERO;
          end else if (tally_reg == `LS_LOCK_COMMAS - `LS_SMALL_ONE) begin
            state_next = LOCKED;
            tally_next = `LS_SMALL_ZERO;
          end else begin
            tally_next = tally_reg + `LS_SMALL_ONE;
          end
        end
      end
      LOCKED: begin
        if (charValid && charCodeError) begin
          state_next = CHECK;
          tally_next = `LS_SMALL_ONE;
        end
      end
      CHECK: begin
        if (charValid && charCodeError) begin
          if (tally_reg == `LS_DROP_ERRORS - `LS_SMALL_ONE) begin
            state_next = HUNT;
            tally_next = `LS_SMALL_ZERO;
          end else begin
            tally_next = tally_reg + `LS_SMALL_ONE;
          end
        end else if (charValid && tally_reg == `LS_SMALL_ONE) begin
          state_next = LOCKED;
          tally_next = `LS_SMALL_ZERO;
        end
      end
      default: begin
        state_next = HUNT;
        tally_next = `LS_SMALL_ZERO;
      end
    endcase
  end

  // State registers, not synchronized out of reset
  always @(posedge clock) begin
    if (rst) begin
      state_reg <= HUNT;
      tally_reg <= `LS_SMALL_ZERO;
    end else begin
      state_reg <= state_next;
      tally_reg <= tally_next;
    end
  end

endmodule // lane_lock_fsm

/* File: hdl/lane_status_top.v */
// Paged per-lane control character and code group lock status with register port
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
`include "lane_status_regs.vh"

module lane_status_top (
  input wire clock,
  input wire rst,
  input wire [11:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdData,
  output wire irq,
  input wire [15:0] charValid,
  input wire [15:0] charIsControl,
  input wire [15:0] controlExpected,
  input wire [15:0] charIsComma,
  input wire [15:0] charCodeError
);

  // ===========================================
  // Helpers

  // Pick the eight lanes of the paged link
  function [7:0] pageSelect;
    input page;
    input [15:0] allLanes;
    begin
      if (page) begin
        pageSelect = allLanes[15:8];
      end else begin
        pageSelect = allLanes[7:0];
      end
    end
  endfunction

  // Write decode for one offset
  function writeHit;
    input wr;
    input [11:0] addr;
    input [11:0] offset;
    begin
      writeHit = wr & (addr == offset);
    end
  endfunction

  // ===========================================
  // Software registers

  reg linkPage_reg;
  reg [7:0] errorCountThreshold_reg;
  reg clearCount_reg;
  reg [2:0] irqStatus_reg;
  reg [2:0] irqStatus_next;
  reg [2:0] irqMask_reg;
  reg [7:0] regRdData_next;

  // ===========================================
  // Lane state

  wire [15:0] badControlCharFlag;
  wire [15:0] codeGroupLock;
  reg [15:0] badFlagSeen_reg;
  reg [15:0] lockSeen_reg;
  wire [2:0] irqEvent;
  wire [7:0] lane_unexpected_control_char_flags;
  wire [7:0] lane_code_group_lock_flags;

  // Per-lane flags for both links, lane n of link 1 at index n plus 8
  genvar lane;
  generate
    for (lane = 0; lane < `LS_ALL_LANES; lane = lane + 1) begin : g_lane
      lane_error_counter u_counter (
        .clock(clock),
        .rst(rst),
        .clearCount(clearCount_reg),
        .charValid(charValid[lane]),
        .charIsControl(charIsControl[lane]),
        .controlExpected(controlExpected[lane]),
        .errorCountThreshold(errorCountThreshold_reg),
        .errorCount_reg(),
        .badControlCharFlag_reg(badControlCharFlag[lane])
      );
      lane_lock_fsm u_lock (
        .clock(clock),
        .rst(rst),
        .charValid(charValid[lane]),
        .charIsComma(charIsComma[lane]),
        .charCodeError(charCodeError[lane]),
        .codeGroupLock(codeGroupLock[lane])
      );
    end
  endgenerate

  // ===========================================
  // Paged status views

  // Both status views follow the link page control
  assign lane_unexpected_control_char_flags = pageSelect(linkPage_reg, badControlCharFlag);
  assign lane_code_group_lock_flags = pageSelect(linkPage_reg, codeGroupLock);

  // ===========================================
  // Control registers

  // Link page, threshold and mask; the flag registers take no writes
  always @(posedge clock) begin
    if (rst) begin
      linkPage_reg <= 1'b0;
      errorCountThreshold_reg <= `LS_RST_THRESHOLD;
      irqMask_reg <= `LS_RST_IRQ;
    end else begin
      if (writeHit(regWrite, regAddr, `LS_OFF_LINK_PAGE)) begin
        linkPage_reg <= regWrData[`LS_PAGE_BIT];
      end
      if (writeHit(regWrite, regAddr, `LS_OFF_THRESHOLD)) begin
        errorCountThreshold_reg <= regWrData;
      end
      if (writeHit(regWrite, regAddr, `LS_OFF_IRQ_MASK)) begin
        irqMask_reg <= regWrData[`LS_IRQ_W-1:0];
      end
    end
  end

  // Counter clear is a one-cycle pulse on a write of one
  always @(posedge clock) begin
    if (rst) begin
      clearCount_reg <= 1'b0;
    end else begin
      clearCount_reg <= writeHit(regWrite, regAddr, `LS_OFF_CNT_CLEAR) & regWrData[`LS_CLEAR_BIT];
    end
  end

  // ===========================================
  // Interrupts

  // Previous flag values for edge detection on every lane of every link
  always @(posedge clock) begin
    if (rst) begin
      badFlagSeen_reg <= 16'h0000;
      lockSeen_reg <= 16'h0000;
    end else begin
      badFlagSeen_reg <= badControlCharFlag;
      lockSeen_reg <= codeGroupLock;
    end
  end

  // Threshold reached, lock lost, lock gained on any lane
  assign irqEvent[`LS_IRQ_KCHAR_BIT] = |(badControlCharFlag & ~badFlagSeen_reg);
  assign irqEvent[`LS_IRQ_LOST_BIT] = |(~codeGroupLock & lockSeen_reg);
  assign irqEvent[`LS_IRQ_GAINED_BIT] = |(codeGroupLock & ~lockSeen_reg);

  // Sticky status, write one to clear, a new event wins over the clear
  always @* begin
    irqStatus_next = irqStatus_reg;
    if (writeHit(regWrite, regAddr, `LS_OFF_IRQ_STATUS)) begin
      irqStatus_next = irqStatus_reg & ~regWrData[`LS_IRQ_W-1:0];
    end
    irqStatus_next = irqStatus_next | irqEvent;
  end

  // Status register
  always @(posedge clock) begin
    if (rst) begin
      irqStatus_reg <= `LS_RST_IRQ;
    end else begin
      irqStatus_reg <= irqStatus_next;
    end
  end

  // Level interrupt while any unmasked status bit is set
  assign irq = |(irqStatus_reg & irqMask_reg);

  // ===========================================
  // Read port

  // Read decode, unmapped offsets read zero
  always @* begin
    regRdData_next = `LS_RD_ZERO;
    case (regAddr)
      `LS_OFF_LINK_PAGE: begin
        regRdData_next = {7'h00, linkPage_reg};
      end
      `LS_OFF_THRESHOLD: begin
        regRdData_next = errorCountThreshold_reg;
      end
      `LS_OFF_IRQ_STATUS: begin
        regRdData_next = {5'h00, irqStatus_reg};
      end
      `LS_OFF_IRQ_MASK: begin
        regRdData_next = {5'h00, irqMask_reg};
      end
      `LS_OFF_KCHAR_FLAGS: begin
        regRdData_next = lane_unexpected_control_char_flags;
      end
      `LS_OFF_LOCK_FLAGS: begin
        regRdData_next = lane_code_group_lock_flags;
      end
      default: begin
        regRdData_next = `LS_RD_ZERO;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clock) begin
    if (rst) begin
      regRdData <= `LS_RST_FLAGS;
    end else if (regRead) begin
      regRdData <= regRdData_next;
    end else begin
      regRdData <= `LS_RD_ZERO;
    end
  end

endmodule // lane_status_top

/* File: verif/lane_status_assertions.sv */
// Port-level assertions for the lane status block
`timescale 1ns/1ns
module lane_status_checker (
  input wire clock,
  input wire rst,
  input wire [11:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regRdData,
  input wire irq
);
  reg [7:0] thrCopy_reg;
  reg [2:0] maskCopy_reg;
  // ===========================================
  // Shadow copies of threshold and interrupt mask
  always @(posedge clock) begin
    if (rst) begin
      thrCopy_reg <= 8'hFF;
      maskCopy_reg <= 3'h0;
    end else if (regWrite) begin
      if (regAddr == 12'h302) thrCopy_reg <= regWrData;
      if (regAddr == 12'h304) maskCopy_reg <= regWrData[2:0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ===========================================
  // Properties
  property p_rd_idle; !regRead |=> regRdData == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_unmapped; regRead && regAddr > 12'h470 |=> regRdData == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_irq_rel; $fell(rst) |-> !irq; endproperty
  a_irq_rel: assert property (p_irq_rel) else $error("irq high after reset");
  property p_irq_mask; irq |-> maskCopy_reg != 3'h0; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq with all masked");
  property p_thr0;
    regRead && regAddr == 12'h46F && thrCopy_reg == 8'h00 && $past(thrCopy_reg) == 8'h00 |=> regRdData == 8'hFF;
  endproperty
  a_thr0: assert property (p_thr0) else $error("zero threshold flags wrong");
  property p_thr_rb; regWrite && regAddr == 12'h302 ##1 regRead && regAddr == 12'h302
    |=> regRdData == $past(regWrData, 2); endproperty
  a_thr_rb: assert property (p_thr_rb) else $error("threshold readback wrong");
  property p_page_rb; regWrite && regAddr == 12'h300 ##1 regRead && regAddr == 12'h300
    |=> regRdData == ($past(regWrData, 2) & 8'h01); endproperty
  a_page_rb: assert property (p_page_rb) else $error("page readback wrong");
  property p_reset_rd; $fell(rst) && regRead && (regAddr == 12'h46F || regAddr == 12'h470)
    |=> regRdData == 8'h00; endproperty
  a_reset_rd: assert property (p_reset_rd) else $error("flags not zero after reset");
endmodule // lane_status_checker

bind lane_status_top lane_status_checker u_chk (.clock(clock), .rst(rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .irq(irq));

/* File: verif/lane_tx_model.sv */
// Behavioural serial lane transmitter feeding decoded characters
`timescale 1ns/1ns
module lane_tx_model (
  input wire clock,
  output reg [15:0] charValid,
  output reg [15:0] charIsControl,
  output reg [15:0] controlExpected,
  output reg [15:0] charIsComma,
  output reg [15:0] charCodeError
);
  initial begin
    charValid = 16'h0000;
    charIsControl = 16'h0000;
    controlExpected = 16'h0000;
    charIsComma = 16'h0000;
    charCodeError = 16'h0000;
  end
  // Kinds: 0 comma, 1 stray control, 2 code error, 3 plain data
  task send(input [15:0] lanes, input [1:0] kind, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        charValid <= lanes;
        charIsComma <= (kind == 2'h0) ? lanes : 16'h0000;
        charIsControl <= (kind < 2'h2) ? lanes : 16'h0000;
        controlExpected <= (kind == 2'h0) ? lanes : 16'h0000;
        charCodeError <= (kind == 2'h2) ? lanes : 16'h0000;
        @(posedge clock);
      end
      // Idle comma, control and code error lines change, so stale values cannot pass for data
      charValid <= 16'h0000;
      charIsComma <= ~charIsComma;
      charIsControl <= ~charIsControl;
      charCodeError <= ~charCodeError;
      @(posedge clock);
    end
  endtask
endmodule // lane_tx_model

/* File: verif/serial_lane_kchar_and_cgs_status_bench.sv */
// Self-checking bench for the lane status block
`timescale 1ns/1ns
module serial_lane_kchar_and_cgs_status_bench;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg [11:0] regAddr = 12'h000;
  reg [7:0] regWrData = 8'h00;
  reg regWrite = 1'b0;
  reg regRead = 1'b0;
  wire [7:0] regRdData;
  wire irq;
  wire [15:0] charValid, charIsControl, controlExpected, charIsComma, charCodeError;
  integer n_errors = 0;
  integer tests_run = 0;
  integer cycles = 0;
  initial forever #20 clock = ~clock;
  lane_status_top u_dut (.clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .irq(irq), .charValid(charValid),
    .charIsControl(charIsControl), .controlExpected(controlExpected), .charIsComma(charIsComma),
    .charCodeError(charCodeError));
  lane_tx_model u_tx (.clock(clock), .charValid(charValid), .charIsControl(charIsControl),
    .controlExpected(controlExpected), .charIsComma(charIsComma), .charCodeError(charCodeError));
  // ===========================================
  // Shared tasks
  task check(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [11:0] a, input [7:0] d);
    begin
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clock);
      regWrite <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [7:0] exp);
    begin
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRead <= 1'b0;
      #1 check(regRdData, exp);
      @(posedge clock);
    end
  endtask
  task irqIs(input bit exp);
    begin
      #1 check({7'h00, irq}, {7'h00, exp});
      @(posedge clock);
    end
  endtask
  task summarize;
    begin
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
        $display("ALL CHECKS OK");
      end else begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask
  // ===========================================
  // Scenarios
  task testReset;
    begin
      rd(12'h470, 8'h00);
      rd(12'h46F, 8'h00);
      rd(12'h302, 8'hFF);
      rd(12'h5A0, 8'h00);
      $display("test reset done");
    end
  endtask
  task testBadChar;
    begin
      wr(12'h302, 8'h02);
      rd(12'h302, 8'h02);
      u_tx.send(16'h0008, 2'h1, 1);
      rd(12'h46F, 8'h00);
      u_tx.send(16'h0008, 2'h0, 1);
      rd(12'h46F, 8'h00);
      u_tx.send(16'h0008, 2'h1, 1);
      rd(12'h46F, 8'h08);
      wr(12'h46F, 8'h00);
      @(posedge clock);
      wr(12'h470, 8'hFF);
      rd(12'h46F, 8'h08);
      rd(12'h470, 8'h00);
      wr(12'h300, 8'h01);
      rd(12'h300, 8'h01);
      rd(12'h46F, 8'h00);
      $display("test bad char done");
    end
  endtask
  task testIrq;
    begin
      rd(12'h303, 8'h01);
      wr(12'h304, 8'h01);
      irqIs(1'b1);
      wr(12'h303, 8'h01);
      irqIs(1'b0);
      rd(12'h303, 8'h00);
      $display("test irq done");
    end
  endtask
  task testLock;
    begin
      u_tx.send(16'hA000, 2'h0, 3);
      rd(12'h470, 8'h00);
      u_tx.send(16'hA000, 2'h0, 1);
      rd(12'h470, 8'hA0);
      wr(12'h300, 8'h00);
      rd(12'h470, 8'h00);
      wr(12'h300, 8'h01);
      u_tx.send(16'hA000, 2'h2, 2);
      rd(12'h470, 8'hA0);
      u_tx.send(16'hA000, 2'h2, 1);
      rd(12'h470, 8'h00);
      $display("test lock done");
    end
  endtask
  task testZeroThreshold;
    begin
      wr(12'h302, 8'h00);
      @(posedge clock);
      rd(12'h46F, 8'hFF);
      $display("test zero threshold done");
    end
  endtask
  // Lane 3 of link 0 holds two bad characters; the clear drops every count
  task testClear;
    begin
      wr(12'h300, 8'h00);
      @(posedge clock);
      wr(12'h302, 8'h02);
      @(posedge clock);
      rd(12'h46F, 8'h08);
      wr(12'h301, 8'h01);
      @(posedge clock);
      rd(12'h46F, 8'h00);
      rd(12'h301, 8'h00);
      $display("test clear done");
    end
  endtask
  // ===========================================
  // Hang guard
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      n_errors = n_errors + 1;
      $display("[ERR] %0t timeout", $time);
      summarize;
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    testReset;
    testBadChar;
    testIrq;
    testLock;
    testZeroThreshold;
    testClear;
    summarize;
  end
endmodule // serial_lane_kchar_and_cgs_status_bench
